// *** shared/panel_pkg.sv ***
// constants, carriers and helpers for the front operator panel controller
package panel_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LAMP_MS = 1000;
  localparam int HOLD_MS = 500;
  localparam int DEB_MS = 10;
  localparam int REP_MS = 50;
  // ---------------------------------------------------------------
  // function map
  // ---------------------------------------------------------------
  localparam int NPARAM = 16;
  localparam logic [9:0] FN_MAX = 10'h3E7;
  localparam logic [9:0] MON_LO = 10'h258;
  localparam logic [9:0] MON_HI = 10'h31F;
  localparam logic [9:0] FN_STORE = 10'h3E2;
  localparam logic [9:0] PORT_LO = 10'h3E3;
  localparam logic [9:0] PORT_HI = 10'h3E7;
  // ---------------------------------------------------------------
  // glyphs, segment a..g in bits 0..6
  // ---------------------------------------------------------------
  typedef logic [6:0] seg_t;
  localparam seg_t G_BL = 7'h00;
  localparam seg_t G_ALL = 7'h7F;
  localparam seg_t G_MID = 7'h40;
  localparam seg_t G_P = 7'h73;
  localparam seg_t G_R = 7'h50;
  localparam seg_t G_O = 7'h5C;
  localparam seg_t G_T = 7'h78;
  localparam seg_t G_U = 7'h3E;
  localparam seg_t G_F = 7'h71;
  localparam seg_t G_L = 7'h38;
  localparam seg_t G_H = 7'h76;
  localparam seg_t G_I = 7'h06;
  localparam seg_t G_N = 7'h54;
  localparam seg_t G_A = 7'h77;
  localparam seg_t G_S = 7'h6D;
  localparam logic [1:0] HALF_ON = 2'h3;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {logic [1:0] half; seg_t [3:0] dig;} disp_s;
  typedef enum logic [3:0] {ST_LAMP = 4'h0, ST_NVCHK = 4'h1, ST_LOAD = 4'h3, ST_FUSE = 4'h2,
    ST_FINAL = 4'h6, ST_FUNC = 4'h7, ST_DATA = 4'h5, ST_NAVAIL = 4'h4, ST_PROT = 4'hC} state_e;
  typedef enum logic [1:0] {LIM_NONE = 2'h0, LIM_LO = 2'h1, LIM_HI = 2'h2} lim_e;
  typedef enum logic [1:0] {INIT_NONE = 2'h0, INIT_RELOAD = 2'h1, INIT_DEFAULT = 2'h2} init_e;
  typedef enum logic [1:0] {K_PARAM = 2'h0, K_MON = 2'h1, K_STORE = 2'h2, K_NONE = 2'h3} kind_e;
  typedef struct packed {logic we; logic [3:0] idx; logic [15:0] data;} pwr_s;
  typedef struct packed {logic stable; logic [7:0] deb; logic [9:0] hold; logic [7:0] rep; logic press;} key_s;
  typedef struct packed {logic [1:0] mode; logic [3:0] ptr;} sweep_s;
  typedef struct packed {
    state_e state; logic [17:0] tick; logic [9:0] tmr; logic [9:0] fn; logic [15:0] pend;
    lim_e lim; logic edit; logic red; logic green; disp_s disp; logic drive_en;
    logic [9:0] mon_sel; logic [15:0] par_val; pwr_s wr; logic store; init_e init;
  } ctl_s;
  // ---------------------------------------------------------------
  // per-parameter bounds, defaults and lock
  // ---------------------------------------------------------------
  function automatic logic [15:0] param_lo(input logic [3:0] i);
    param_lo = {12'h000, i};
  endfunction : param_lo
  function automatic logic [15:0] param_hi(input logic [3:0] i);
    param_hi = 16'h0064 + {8'h00, i, 4'h0};
  endfunction : param_hi
  function automatic logic [15:0] param_def(input logic [3:0] i);
    param_def = 16'h0020 + {12'h000, i};
  endfunction : param_def
  function automatic logic param_ro(input logic [3:0] i);
    param_ro = (i == 4'hF);
  endfunction : param_ro
  function automatic kind_e fn_kind(input logic [9:0] f);
    if (f < 10'(NPARAM)) fn_kind = K_PARAM;
    else if (f >= MON_LO && f <= MON_HI) fn_kind = K_MON;
    else if (f == FN_STORE) fn_kind = K_STORE;
    else fn_kind = K_NONE;
  endfunction : fn_kind
  function automatic seg_t dec7(input logic [3:0] d);
    seg_t t [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
    dec7 = (d < 4'hA) ? t[d] : G_MID;
  endfunction : dec7
  // binary to half digit plus four decimal digits, double dabble
  function automatic disp_s disp_num(input logic [15:0] v);
    logic [35:0] s;
    s = {20'h00000, v};
    for (int k = 0; k < 16; k++)
    begin
      for (int j = 0; j < 5; j++)
        if (s[16 + 4 * j +: 4] > 4'h4) s[16 + 4 * j +: 4] = s[16 + 4 * j +: 4] + 4'h3;
      s = {s[34:0], 1'b0};
    end
    disp_num.half = (s[35:32] != 4'h0) ? HALF_ON : 2'h0;
    for (int j = 0; j < 4; j++) disp_num.dig[j] = dec7(s[16 + 4 * j +: 4]);
  endfunction : disp_num
endpackage : panel_pkg

// *** rtl/key_event.sv ***
// debounce and auto-repeat for one panel key
`timescale 1ns/1ps
module key_event
  import panel_pkg::*;
#(
  parameter int DEB = DEB_MS,
  parameter int HOLD = HOLD_MS,
  parameter int REP = REP_MS,
  parameter bit REPEAT = 1'b1
)(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic raw,
  output logic press
);
  key_s k_q;
  key_s k_d;

  // ---------------------------------------------------------------
  // filter on the ms tick: bounce shorter than DEB never reaches the fsm
  // ---------------------------------------------------------------
  always_comb
  begin
    k_d = k_q;
    k_d.press = 1'b0;
    if (tick)
    begin
      if (raw != k_q.stable)
      begin
        k_d.deb = k_q.deb + 8'h1;
        if (k_q.deb == 8'(DEB - 1))
        begin
          k_d.stable = raw;
          k_d.deb = '0;
          k_d.hold = '0;
          k_d.rep = '0;
          k_d.press = raw; // RULE24
        end
      end
      else
      begin
        k_d.deb = '0;
        if (REPEAT && k_q.stable)
        begin
          if (k_q.hold != 10'(HOLD)) k_d.hold = k_q.hold + 10'h1;
          else if (k_q.rep == 8'(REP - 1))
          begin
            k_d.rep = '0;
            k_d.press = 1'b1; // RULE12
          end
          else k_d.rep = k_q.rep + 8'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst) k_q <= '0;
    else k_q <= k_d;
  end

  assign press = k_q.press;

  property p_single_press;
    @(posedge core_clk) disable iff (sys_rst) k_q.press |=> !k_q.press;
  endproperty
  a_single_press: assert property (p_single_press) else $error("key event longer than one cycle"); // RULE24
endmodule : key_event

// *** rtl/param_store.sv ***
// active and nonvolatile parameter copies with reload, default and store sweeps
`timescale 1ns/1ps
module param_store
  import panel_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire init_e init,
  input wire logic store,
  input wire pwr_s wr,
  input wire logic [3:0] rd_a_idx,
  input wire logic [3:0] rd_b_idx,
  output logic [15:0] rd_a,
  output logic [15:0] rd_b,
  output logic busy
);
  localparam logic [1:0] M_IDLE = 2'h0;
  localparam logic [1:0] M_STORE = 2'h3;
  logic [15:0] active [NPARAM];
  logic [15:0] nv [NPARAM]; // never reset: this is the retained copy
  sweep_s s_q;
  sweep_s s_d;

  // ---------------------------------------------------------------
  // sweep one word a cycle; commands are ignored while one runs
  // ---------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    if (s_q.mode == M_IDLE)
    begin
      s_d.ptr = '0;
      if (init != INIT_NONE) s_d.mode = init;
      else if (store) s_d.mode = M_STORE;
    end
    else
    begin
      s_d.ptr = s_q.ptr + 4'h1;
      if (s_q.ptr == 4'(NPARAM - 1)) s_d.mode = M_IDLE;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst) s_q <= '0;
    else s_q <= s_d;
  end

  // arrays hold no reset on purpose
  always_ff @(posedge core_clk)
  begin
    if (s_q.mode == 2'(INIT_RELOAD)) active[s_q.ptr] <= nv[s_q.ptr]; // RULE19
    else if (s_q.mode == 2'(INIT_DEFAULT))
    begin
      active[s_q.ptr] <= param_def(s_q.ptr); // RULE3
      nv[s_q.ptr] <= param_def(s_q.ptr);
    end
    else if (s_q.mode == M_STORE) nv[s_q.ptr] <= active[s_q.ptr]; // RULE20
    else if (wr.we) active[wr.idx] <= wr.data;
  end

  assign rd_a = active[rd_a_idx];
  assign rd_b = active[rd_b_idx];
  assign busy = (s_q.mode != M_IDLE);

  property p_store_sweep;
    @(posedge core_clk) disable iff (sys_rst) (s_q.mode == M_IDLE && store && init == INIT_NONE)
      |=> s_q.mode == M_STORE && s_q.ptr == 4'h0;
  endproperty
  a_store_sweep: assert property (p_store_sweep) else $error("store request not started"); // RULE20
endmodule : param_store

// *** rtl/panel_ctrl.sv ***
// front operator panel controller: power-up sequence and function/data menu
// Notes on behaviour
// RULE1: power-up first lights every display segment with both level leds off
// RULE2: the lamp test holds for about one second
// RULE3: then check nonvolatile data; load defaults, or show protect when locked
// RULE4: operator unlocks, resets for defaults, then relocks the write lock
// RULE5: an open line fuse lights the middle segment of its matching right digit
// RULE6: the drive stays disabled while any of the three fuses is open
// RULE7: after tests show F plus three-digit fault number, else power-up message
// RULE8: power-up message stays until any key press or a fault
// RULE9: function numbers span one thousand functions
// RULE10: both level leds are off at the function level
// RULE11: up adds one, down subtracts one from the function number per press
// RULE12: a key held half a second or more auto-repeats; the code repeats only up and down, toggle and enter never do
// RULE13: toggle key enters data level with green lit, again returns with leds off
// RULE14: portable-panel-only functions show not-available instead of data level
// RULE15: up and down change a pending value, red lit while it differs; the code lights red after any up or down until enter or toggle
// RULE16: each parameter has bounds; stepping past one shows a limit indication
// RULE17: enter commits the pending value, red off and green on
// RULE18: enter on a limit indication clamps to that bound, shows it, green on
// RULE19: committed values last until reset, then reload from nonvolatile copy
// RULE20: the store function writes active values into nonvolatile memory
// RULE21: enter on an unchangeable parameter discards the change
// RULE22: monitor functions show live values with green lit, updating at once
// RULE23: monitor functions ignore up, down and enter
// RULE24: each debounced press is one single action
`timescale 1ns/1ps
module panel_ctrl
  import panel_pkg::*;
#(
  parameter int TICK_CYC_P = TICK_CYC
)(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic level_toggle_key,
  input wire logic key_enter,
  input wire logic write_lock_switch,
  input wire logic nv_valid,
  input wire logic [2:0] fuse_open,
  input wire logic fault_active,
  input wire logic [9:0] fault_code,
  input wire logic [15:0] mon_value,
  input wire logic [3:0] par_sel,
  output disp_s disp,
  output logic led_red,
  output logic led_green,
  output logic drive_enable,
  output logic [9:0] mon_sel,
  output logic [15:0] par_val
);
  ctl_s st_q;
  ctl_s st_d;
  logic tick;
  logic [3:0] raw;
  logic [3:0] ev;
  logic [15:0] rd_a;
  logic [15:0] rd_b;
  logic busy;
  logic [3:0] pidx;
  logic any_key;
  disp_s fault_disp;

  // ---------------------------------------------------------------
  // ms tick divider and key events
  // ---------------------------------------------------------------
  assign tick = (st_q.tick == 18'(TICK_CYC_P - 1));
  assign raw = {key_enter, level_toggle_key, key_down, key_up};
  assign any_key = |ev;
  assign pidx = st_q.fn[3:0];

  // up and down repeat; toggle and enter never do
  for (genvar i = 0; i < 4; i++)
  begin : g_key
    key_event #(
      .DEB(DEB_MS),
      .HOLD(HOLD_MS),
      .REP(REP_MS),
      .REPEAT(i < 2)
    ) u_key (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .raw(raw[i]),
      .press(ev[i])
    );
  end

  param_store u_store (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .init(st_q.init),
    .store(st_q.store),
    .wr(st_q.wr),
    .rd_a_idx(pidx),
    .rd_b_idx(par_sel),
    .rd_a(rd_a),
    .rd_b(rd_b),
    .busy(busy)
  );

  // fault code shown as F and three digits
  always_comb
  begin
    fault_disp = disp_num({6'h00, fault_code});
    fault_disp.half = 2'h0;
    fault_disp.dig[3] = G_F; // RULE7
  end

  // ---------------------------------------------------------------
  // sequence and menu
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.tick = tick ? 18'h0 : st_q.tick + 18'h1;
    st_d.wr = '0;
    st_d.store = 1'b0;
    st_d.init = INIT_NONE;
    st_d.mon_sel = st_q.fn;
    st_d.par_val = rd_b;
    unique case (st_q.state)
      ST_LAMP:
      begin
        if (tick)
        begin
          st_d.tmr = st_q.tmr + 10'h1;
          if (st_q.tmr == 10'(LAMP_MS - 1)) st_d.state = ST_NVCHK; // RULE2
        end
      end
      ST_NVCHK:
      begin
        // the copy is loaded only once the lamp test has ended
        if (nv_valid)
        begin
          st_d.init = INIT_RELOAD; // RULE19
          st_d.state = ST_LOAD;
        end
        else if (!write_lock_switch)
        begin
          st_d.init = INIT_DEFAULT; // RULE3
          st_d.state = ST_LOAD;
        end
        else st_d.state = ST_PROT; // RULE3
      end
      ST_LOAD:
      begin
        if (st_q.init == INIT_NONE && !busy) st_d.state = ST_FUSE;
      end
      ST_PROT:
      begin
        // only a reset leaves here, after the operator unlocks
        st_d.state = ST_PROT; // RULE4
      end
      ST_FUSE:
      begin
        // a blown fuse holds here; once all three fuses read closed the final display follows
        if (fuse_open == 3'h0) st_d.state = ST_FINAL;
      end
      ST_FINAL:
      begin
        if (any_key) st_d.state = ST_FUNC; // RULE8
      end
      ST_FUNC:
      begin
        if (ev[0] && st_q.fn != FN_MAX) st_d.fn = st_q.fn + 10'h1; // RULE11 RULE9
        else if (ev[1] && st_q.fn != 10'h0) st_d.fn = st_q.fn - 10'h1; // RULE11
        else if (ev[2])
        begin
          st_d.pend = rd_a;
          st_d.lim = LIM_NONE;
          st_d.edit = 1'b0;
          if (fn_kind(st_q.fn) == K_NONE) st_d.state = ST_NAVAIL; // RULE14
          else st_d.state = ST_DATA; // RULE13
        end
      end
      ST_NAVAIL:
      begin
        if (ev[2]) st_d.state = ST_FUNC;
      end
      ST_DATA:
      begin
        if (ev[2])
        begin
          st_d.state = ST_FUNC; // RULE13
          st_d.lim = LIM_NONE;
          st_d.edit = 1'b0;
        end
        else if (fn_kind(st_q.fn) == K_STORE)
        begin
          if (ev[3] && !busy) st_d.store = 1'b1; // RULE20
        end
        else if (fn_kind(st_q.fn) == K_PARAM)
        begin
          if (ev[0])
          begin
            st_d.edit = 1'b1; // RULE15
            if (st_q.lim == LIM_LO) st_d.lim = LIM_NONE;
            else if (st_q.pend >= param_hi(pidx)) st_d.lim = LIM_HI; // RULE16
            else st_d.pend = st_q.pend + 16'h1;
          end
          else if (ev[1])
          begin
            st_d.edit = 1'b1; // RULE15
            if (st_q.lim == LIM_HI) st_d.lim = LIM_NONE;
            else if (st_q.pend <= param_lo(pidx)) st_d.lim = LIM_LO; // RULE16
            else st_d.pend = st_q.pend - 16'h1;
          end
          else if (ev[3])
          begin
            st_d.edit = 1'b0;
            st_d.lim = LIM_NONE;
            st_d.wr.idx = pidx;
            if (param_ro(pidx)) st_d.pend = rd_a; // RULE21
            else
            begin
              st_d.wr.we = 1'b1; // RULE17
              if (st_q.lim == LIM_LO) st_d.pend = param_lo(pidx); // RULE18
              else if (st_q.lim == LIM_HI) st_d.pend = param_hi(pidx); // RULE18
              st_d.wr.data = st_d.pend;
            end
          end
        end
        // monitor functions take no action on up, down or enter
      end
      default:
      begin
        st_d.state = ST_LAMP;
      end
    endcase

    // drive, led and display outputs follow the next state so they never lag it; mon_sel lags fn by one cycle
    st_d.drive_en = (st_d.state == ST_FINAL || st_d.state == ST_FUNC || st_d.state == ST_DATA
      || st_d.state == ST_NAVAIL) && fuse_open == 3'h0; // RULE6
    st_d.red = (st_d.state == ST_DATA) && st_d.edit; // RULE15
    st_d.green = (st_d.state == ST_DATA) && !st_d.edit; // RULE13 RULE17 RULE22
    st_d.disp = '0;
    unique case (st_d.state)
      ST_LAMP:
      begin
        st_d.disp = {HALF_ON, G_ALL, G_ALL, G_ALL, G_ALL}; // RULE1
        st_d.red = 1'b0;
        st_d.green = 1'b0;
      end
      ST_PROT: st_d.disp.dig = {G_P, G_R, G_O, G_T}; // RULE3
      ST_FUSE:
      begin
        st_d.disp.dig[2] = fuse_open[0] ? G_MID : G_BL; // RULE5
        st_d.disp.dig[1] = fuse_open[1] ? G_MID : G_BL; // RULE5
        st_d.disp.dig[0] = fuse_open[2] ? G_MID : G_BL; // RULE5
      end
      ST_FINAL:
      begin
        if (fault_active) st_d.disp = fault_disp; // RULE7 RULE8
        else st_d.disp.dig = {G_P, G_MID, G_U, G_P}; // RULE7
      end
      ST_FUNC: st_d.disp = disp_num({6'h00, st_d.fn}); // RULE10
      ST_NAVAIL: st_d.disp.dig = {G_N, G_A, G_BL, G_BL}; // RULE14
      ST_DATA:
      begin
        unique case (fn_kind(st_d.fn))
          K_MON: st_d.disp = disp_num(mon_value); // RULE22
          K_STORE: st_d.disp.dig = {G_S, G_T, G_O, G_R};
          K_PARAM:
          begin
            if (st_d.lim == LIM_LO) st_d.disp.dig = {G_BL, G_L, G_O, G_BL}; // RULE16
            else if (st_d.lim == LIM_HI) st_d.disp.dig = {G_BL, G_H, G_I, G_BL}; // RULE16
            else st_d.disp = disp_num(st_d.pend);
          end
          K_NONE: st_d.disp.dig = {G_N, G_A, G_BL, G_BL};
        endcase
      end
      default: st_d.disp = '0;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst) st_q <= '0;
    else st_q <= st_d;
  end

  assign disp = st_q.disp;
  assign led_red = st_q.red;
  assign led_green = st_q.green;
  assign drive_enable = st_q.drive_en;
  assign mon_sel = st_q.mon_sel;
  assign par_val = st_q.par_val;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  property p_lamp_show;
    (st_q.state == ST_LAMP && st_q.tmr != 10'h0)
      |-> disp == {HALF_ON, G_ALL, G_ALL, G_ALL, G_ALL} && !led_red && !led_green;
  endproperty
  a_lamp_show: assert property (p_lamp_show) else $error("lamp test display wrong"); // RULE1

  property p_lamp_hold;
    (st_q.state == ST_LAMP && st_q.tmr != 10'(LAMP_MS - 1)) |=> st_q.state == ST_LAMP;
  endproperty
  a_lamp_hold: assert property (p_lamp_hold) else $error("lamp test ended early"); // RULE2

  property p_fuse_block;
    fuse_open != 3'h0 |=> !drive_enable;
  endproperty
  a_fuse_block: assert property (p_fuse_block) else $error("drive enabled with open fuse"); // RULE6

  property p_func_leds;
    st_q.state == ST_FUNC |-> !led_red && !led_green;
  endproperty
  a_func_leds: assert property (p_func_leds) else $error("leds lit at function level"); // RULE10

  property p_step_up;
    (st_q.state == ST_FUNC && ev[0] && st_q.fn != FN_MAX) |=> st_q.fn == $past(st_q.fn) + 10'h1;
  endproperty
  a_step_up: assert property (p_step_up) else $error("function number did not step up"); // RULE11

  property p_enter_data;
    (st_q.state == ST_FUNC && ev[2] && !ev[0] && !ev[1] && fn_kind(st_q.fn) == K_PARAM)
      |=> st_q.state == ST_DATA && led_green && !led_red;
  endproperty
  a_enter_data: assert property (p_enter_data) else $error("toggle did not enter data level"); // RULE13

  property p_mon_ro;
    (st_q.state == ST_DATA && fn_kind(st_q.fn) == K_MON) |=> !st_q.wr.we && !st_q.store;
  endproperty
  a_mon_ro: assert property (p_mon_ro) else $error("monitor function wrote a value"); // RULE23

  property p_clamp_lim;
    (st_q.state == ST_DATA && fn_kind(st_q.fn) == K_PARAM && st_q.lim != LIM_NONE && ev == 4'h8
      && !param_ro(pidx)) |=> st_q.wr.we && led_green
      && st_q.wr.data == (($past(st_q.lim) == LIM_HI) ? param_hi($past(pidx)) : param_lo($past(pidx)));
  endproperty
  a_clamp_lim: assert property (p_clamp_lim) else $error("limit not clamped"); // RULE18

  property p_ro_keep;
    (st_q.state == ST_DATA && fn_kind(st_q.fn) == K_PARAM && param_ro(pidx) && ev[3] && !ev[2])
      |=> !st_q.wr.we;
  endproperty
  a_ro_keep: assert property (p_ro_keep) else $error("locked parameter was written"); // RULE21

  c_prot: cover property (st_q.state == ST_PROT);
  c_pup_key: cover property (st_q.state == ST_FINAL ##1 st_q.state == ST_FUNC);
  c_commit: cover property (st_q.wr.we);
  c_store: cover property (st_q.store);
endmodule : panel_ctrl

// *** test/key_operator.sv ***
// operator model: panel key presses and the write lock
`timescale 1ns/1ps
module key_operator
  import panel_pkg::*;
(
  input wire logic core_clk,
  input wire logic [9:0] mon_sel,
  output logic [3:0] keys,
  output logic write_lock_switch
);
  // ---------------------------------------------------------------
  // key actions; one tick is one clock in this bench
  // ---------------------------------------------------------------
  initial
  begin
    keys = 4'h0;
    write_lock_switch = 1'b1;
  end
  // hold and gap both well past the debounce, so a press shorter than the repeat hold is one event
  task automatic press(input int k, input int n);
    @(negedge core_clk);
    keys[k] = 1'b1;
    repeat (n) @(negedge core_clk);
    keys[k] = 1'b0;
    repeat (20) @(negedge core_clk);
  endtask : press
  // hold up until the wanted function shows
  task automatic ramp(input logic [9:0] target, output bit ok);
    int n;
    n = 0;
    @(negedge core_clk);
    keys[0] = 1'b1;
    while (mon_sel < target && n < 40000)
    begin
      @(negedge core_clk);
      n++;
    end
    keys[0] = 1'b0;
    ok = (n < 40000);
    repeat (20) @(negedge core_clk);
  endtask : ramp
  // unlock for a default load, lock again afterwards
  task automatic set_lock(input logic v);
    @(negedge core_clk);
    write_lock_switch = v;
  endtask : set_lock
endmodule : key_operator

// *** test/keypad_display_menu_controller_test.sv ***
// self-checking bench for the panel controller power-up and menu
`timescale 1ns/1ps
module keypad_display_menu_controller_test
  import panel_pkg::*;
;
  logic core_clk, sys_rst, write_lock_switch, nv_valid, fault_active, led_red, led_green, drive_enable;
  logic [3:0] keys, par_sel;
  logic [2:0] fuse_open;
  logic [9:0] fault_code, mon_sel;
  logic [15:0] mon_value, par_val;
  disp_s disp;
  int errors, compares, seed;
  bit ok;
  typedef struct {int sig; logic [31:0] exp; string nm;} note_s;
  note_s q[$];
  event look;
  seg_t num_g [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
  // ---------------------------------------------------------------
  // design, operator and clock
  // ---------------------------------------------------------------
  panel_ctrl #(.TICK_CYC_P(1)) uut (.core_clk(core_clk), .sys_rst(sys_rst), .key_up(keys[0]),
    .key_down(keys[1]), .level_toggle_key(keys[2]), .key_enter(keys[3]), .write_lock_switch(write_lock_switch),
    .nv_valid(nv_valid), .fuse_open(fuse_open), .fault_active(fault_active), .fault_code(fault_code),
    .mon_value(mon_value), .par_sel(par_sel), .disp(disp), .led_red(led_red), .led_green(led_green),
    .drive_enable(drive_enable), .mon_sel(mon_sel), .par_val(par_val));
  key_operator op (.core_clk(core_clk), .mon_sel(mon_sel), .keys(keys), .write_lock_switch(write_lock_switch));
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ---------------------------------------------------------------
  // notes, watcher and verdict
  // ---------------------------------------------------------------
  task automatic expect_v(input int sig, input logic [31:0] exp, input string nm);
    q.push_back('{sig, exp, nm});
    ->look;
  endtask : expect_v
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // watcher samples outputs as each note arrives
  initial
  begin
    note_s n;
    logic [31:0] v;
    forever
    begin
      @(look);
      while (q.size() > 0)
      begin
        n = q.pop_front();
        case (n.sig)
          0: v = 32'(disp);
          1: v = 32'(disp.dig);
          2: v = {30'h0, led_red, led_green};
          3: v = 32'(drive_enable);
          4: v = 32'(mon_sel);
          5: v = 32'(par_val);
          default: v = 32'(disp.dig[0]);
        endcase
        check(n.nm, v, n.exp);
      end
    end
  end
  task automatic report_and_stop(input int extra);
    errors += extra;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (99000) @(posedge core_clk);
    report_and_stop(1);
  end
  // reset held five cycles, power-up inputs applied
  task automatic power_up(input logic nv, input logic [2:0] fu, input logic flt);
    @(negedge core_clk);
    nv_valid = nv;
    fuse_open = fu;
    fault_active = flt;
    sys_rst = 1'b1;
    repeat (5) @(negedge core_clk);
    sys_rst = 1'b0;
  endtask : power_up
  task automatic key(input int k);
    op.press(k, 15);
  endtask : key
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    errors = 0;
    compares = 0;
    seed = 32'hD82C;
    sys_rst = 1'b1;
    {nv_valid, fault_active, fuse_open, par_sel} = '0;
    fault_code = 10'($unsigned($random(seed)) % 1000);
    mon_value = 16'h0000;
    power_up(1'b0, 3'h0, 1'b0);
    repeat (3) @(negedge core_clk);
    expect_v(0, 32'({HALF_ON, {4{G_ALL}}}), "lamp display");
    expect_v(2, 32'h0, "lamp leds");
    repeat (985) @(negedge core_clk);
    expect_v(0, 32'({HALF_ON, {4{G_ALL}}}), "lamp late");
    repeat (60) @(negedge core_clk);
    expect_v(1, {4'h0, G_P, G_R, G_O, G_T}, "protect text");
    op.set_lock(1'b0);
    power_up(1'b0, 3'h1, 1'b0);
    repeat (1100) @(negedge core_clk);
    expect_v(1, {4'h0, G_BL, G_MID, G_BL, G_BL}, "fuse digits");
    expect_v(3, 32'h0, "fuse drive enable");
    op.set_lock(1'b1);
    power_up(1'b1, 3'h0, 1'b1);
    repeat (1100) @(negedge core_clk);
    expect_v(6, 32'(num_g[fault_code % 10]), "fault units");
    expect_v(3, 32'h1, "fault drive enable");
    power_up(1'b1, 3'h0, 1'b0);
    repeat (1300) @(negedge core_clk);
    expect_v(1, {4'h0, G_P, G_MID, G_U, G_P}, "power-up text");
    key(0);
    expect_v(4, 32'h0, "fn at p-up");
    key(0);
    expect_v(4, 32'h1, "fn after up");
    expect_v(2, 32'h0, "function leds");
    key(2);
    expect_v(2, 32'h1, "data leds");
    key(0);
    expect_v(2, 32'h2, "pending leds");
    par_sel = 4'h1;
    key(3);
    expect_v(5, 32'd34, "committed value");
    expect_v(2, 32'h1, "commit leds");
    op.press(1, 2400);
    expect_v(1, {4'h0, G_BL, G_L, G_O, G_BL}, "below limit text");
    key(3);
    expect_v(5, 32'd1, "clamped value");
    expect_v(2, 32'h1, "clamp leds");
    key(2);
    expect_v(2, 32'h0, "back to function");
    repeat (14) key(0);
    par_sel = 4'hF;
    key(2);
    key(0);
    key(3);
    expect_v(5, 32'd47, "locked value");
    key(2);
    op.ramp(10'd600, ok);
    if (!ok) report_and_stop(1);
    expect_v(4, 32'd600, "monitor fn");
    mon_value = 16'($unsigned($random(seed)) % 10);
    key(2);
    expect_v(2, 32'h1, "monitor leds");
    expect_v(6, 32'(num_g[mon_value]), "monitor units");
    @(negedge core_clk);
    mon_value = (mon_value + 16'h0003) % 16'h000A;
    repeat (3) @(negedge core_clk);
    expect_v(6, 32'(num_g[mon_value]), "monitor refresh");
    key(0);
    key(3);
    expect_v(4, 32'd600, "monitor keys fn");
    expect_v(6, 32'(num_g[mon_value]), "monitor keys value");
    key(2);
    op.ramp(10'd994, ok);
    if (!ok) report_and_stop(1);
    key(2);
    key(3);
    repeat (40) @(negedge core_clk);
    key(2);
    key(0);
    expect_v(4, 32'd995, "top fn");
    key(2);
    expect_v(2, 32'h0, "not available leds");
    expect_v(1, {4'h0, G_N, G_A, G_BL, G_BL}, "nA text");
    par_sel = 4'h1;
    power_up(1'b1, 3'h0, 1'b0);
    repeat (1300) @(negedge core_clk);
    expect_v(5, 32'd1, "reloaded value");
    repeat (5) @(negedge core_clk);
    report_and_stop(0);
  end
endmodule : keypad_display_menu_controller_test
